//--- verif/xbc_area_config_tb.sv
/*
 * Self-checking bench of the area configuration bank: register port, access snapshot, bus release.
 * Assumes the design samples strobes at the rising edge and answers reads one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module xbc_area_config_tb;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [1:0] mode_pins_in = 2'h0;
	logic hw_standby_in = 1'b0;
	logic [15:0] addr_in = 16'h0000;
	logic [7:0] wr_data_in = 8'h00;
	logic wr_en_in = 1'b0;
	logic rd_en_in = 1'b0;
	logic access_start_in = 1'b0;
	logic [2:0] access_area_in = 3'h0;
	logic access_onchip_in = 1'b0;
	logic access_done_in = 1'b0;
	logic want = 1'b0;
	wire logic [7:0] rd_data_out;
	xbc_pkg::xbc_spec_t access_spec_out;
	wire logic bus_busy_out, bus16_mode_out, port4_gpio_out, release_pins_gpio_out;
	wire logic req_n, bus_ack_n_out, bus_ack_oe_out, bus_granted_out, owns;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic [7:0] w_sh, a_sh, e_sh, wc_sh;
	xbc_pkg::xbc_eff_wait_t km[4] = '{xbc_pkg::XBC_EW_PROGRAM, xbc_pkg::XBC_EW_NONE,
		xbc_pkg::XBC_EW_PIN1, xbc_pkg::XBC_EW_PIN_AUTO};

	always #10 clk_in = ~clk_in;

	xbc_area_config u_xbc_area_config (.clk_in(clk_in), .rst_in(rst_in), .mode_pins_in(mode_pins_in),
		.hw_standby_in(hw_standby_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
		.rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .access_start_in(access_start_in),
		.access_area_in(access_area_in), .access_onchip_in(access_onchip_in),
		.access_done_in(access_done_in), .access_spec_out(access_spec_out), .bus_busy_out(bus_busy_out),
		.bus16_mode_out(bus16_mode_out), .port4_gpio_out(port4_gpio_out),
		.release_pins_gpio_out(release_pins_gpio_out), .bus_release_request_n_in(req_n),
		.bus_ack_n_out(bus_ack_n_out), .bus_ack_oe_out(bus_ack_oe_out), .bus_granted_out(bus_granted_out));

	xbc_ext_master u_xbc_ext_master (.clk_in(clk_in), .rst_in(rst_in), .want_in(want),
		.bus_ack_n_in(bus_ack_n_out), .bus_release_request_n_out(req_n), .owns_bus_out(owns));

	// ========================================
	// reporting
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// a hung handshake must still end in the report
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_errors++;
			complete_run();
		end
	end

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	// ========================================
	// register port
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string nm);
		@(posedge clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk(nm, e, rd_data_out);
	endtask

	task automatic do_reset(input logic [1:0] m);
		@(posedge clk_in);
		mode_pins_in <= m;
		rst_in <= 1'b1;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
	endtask

	// ========================================
	// access snapshot
	function automatic xbc_pkg::xbc_spec_t ex(input logic [2:0] ar, input logic oc);
		xbc_pkg::xbc_spec_t s;
		s = '0;
		s.bus16 = oc | ~w_sh[ar];
		s.three_state = ~oc & a_sh[ar];
		s.wait_count = wc_sh[1:0];
		if (!s.three_state)
			s.wait_kind = xbc_pkg::XBC_EW_NONE;
		else if (!e_sh[ar])
			s.wait_kind = xbc_pkg::XBC_EW_PIN0;
		else
			s.wait_kind = km[wc_sh[3:2]];
		s.pin_wait_allowed = (s.wait_kind == xbc_pkg::XBC_EW_PIN0) || (s.wait_kind == xbc_pkg::XBC_EW_PIN1)
			|| (s.wait_kind == xbc_pkg::XBC_EW_PIN_AUTO);
		return s;
	endfunction

	// the count is compared only in program wait mode, though the pin wait 1 and pin auto modes carry it too
	function automatic logic [7:0] pk(input xbc_pkg::xbc_spec_t s);
		logic [1:0] c;
		c = (s.wait_kind == xbc_pkg::XBC_EW_PROGRAM) ? s.wait_count : 2'h0;
		return {s.pin_wait_allowed, s.bus16, s.three_state, s.wait_kind, c};
	endfunction

	task automatic acc(input logic [2:0] ar, input logic oc);
		xbc_pkg::xbc_spec_t s;
		s = ex(ar, oc);
		@(posedge clk_in);
		access_area_in <= ar;
		access_onchip_in <= oc;
		access_start_in <= 1'b1;
		@(posedge clk_in);
		access_start_in <= 1'b0;
		#1;
		chk("busy", 8'h01, {7'h00, bus_busy_out});
		chk("spec", pk(s), pk(access_spec_out));
		wr(16'hFFED, ~a_sh);
		wr(16'hFFED, a_sh);
		chk("spec held", pk(s), pk(access_spec_out));
		@(posedge clk_in);
		access_done_in <= 1'b1;
		@(posedge clk_in);
		access_done_in <= 1'b0;
		#1;
		chk("idle", 8'h00, {7'h00, bus_busy_out});
	endtask

	task automatic wait_ack(input logic lvl);
		int n;
		n = 0;
		while (bus_ack_n_out !== lvl && n < 20)
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		chk("ack_n", {7'h00, lvl}, {7'h00, bus_ack_n_out});
	endtask

	// ========================================
	// tests
	initial
	begin
		for (int m = 0; m < 4; m++)
		begin
			do_reset(m[1:0]);
			rdchk(16'hFFEC, m[0] ? 8'h00 : 8'hFF, "width");
			rdchk(16'hFFED, 8'hFF, "state");
			rdchk(16'hFFEE, 8'hF3, "wait ctl");
			rdchk(16'hFFEF, 8'hFF, "wait en");
			rdchk(16'hFFF3, 8'hFE, "release");
			chk("port4", {7'h00, ~m[0]}, {7'h00, port4_gpio_out});
			chk("bus16", {7'h00, m[0]}, {7'h00, bus16_mode_out});
			wr(16'hFFF3, 8'h00);
			rdchk(16'hFFF3, m[1] ? 8'h1E : 8'hFE, "release rw");
		end
		$display("test reset_values done");
		do_reset(2'h0);
		wr(16'hFFEE, 8'h05);
		rdchk(16'hFFEE, 8'hF5, "wait ctl ro");
		wr(16'hFFF0, 8'h5A);
		rdchk(16'hFFF0, 8'h00, "unmapped");
		w_sh = 8'h0F;
		a_sh = 8'hAA;
		e_sh = 8'hF0;
		wr(16'hFFEC, w_sh);
		wr(16'hFFED, a_sh);
		wr(16'hFFEF, e_sh);
		rdchk(16'hFFEC, w_sh, "width rw");
		rdchk(16'hFFED, a_sh, "state rw");
		rdchk(16'hFFEF, e_sh, "wait en rw");
		chk("bus16 wide", 8'h01, {7'h00, bus16_mode_out});
		chk("port4 wide", 8'h00, {7'h00, port4_gpio_out});
		$display("test register_port done");
		for (int m = 0; m < 4; m++)
		begin
			wc_sh = {4'hF, m[1:0], m[1:0] ^ 2'h2};
			wr(16'hFFEE, wc_sh);
			for (int ar = 0; ar < 8; ar++)
				acc(ar[2:0], 1'b0);
			acc(3'h5, 1'b1);
		end
		$display("test access_spec done");
		want <= 1'b1;
		repeat (12) @(posedge clk_in);
		#1;
		chk("ack off", 8'h01, {7'h00, bus_ack_n_out});
		chk("oe off", 8'h00, {7'h00, bus_ack_oe_out});
		chk("pins gpio", 8'h01, {7'h00, release_pins_gpio_out});
		wr(16'hFFF3, 8'h01);
		wait_ack(1'b0);
		chk("granted", 8'h01, {7'h00, bus_granted_out});
		chk("pins bus", 8'h00, {7'h00, release_pins_gpio_out});
		chk("oe on", 8'h01, {7'h00, bus_ack_oe_out});
		chk("owns", 8'h01, {7'h00, owns});
		@(posedge clk_in);
		access_start_in <= 1'b1;
		@(posedge clk_in);
		access_start_in <= 1'b0;
		@(posedge clk_in);
		#1;
		chk("start refused", 8'h00, {7'h00, bus_busy_out});
		want <= 1'b0;
		wait_ack(1'b1);
		chk("owns off", 8'h00, {7'h00, owns});
		$display("test bus_release done");
		wr(16'hFFEC, 8'h55);
		wr(16'hFFEE, 8'h00);
		@(posedge clk_in);
		hw_standby_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		hw_standby_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		rdchk(16'hFFEC, 8'hFF, "sb width");
		rdchk(16'hFFED, 8'hFF, "sb state");
		rdchk(16'hFFEE, 8'hF3, "sb wait ctl");
		rdchk(16'hFFEF, 8'hFF, "sb wait en");
		rdchk(16'hFFF3, 8'hFE, "sb release");
		$display("test hw_standby done");
		complete_run();
	end
endmodule

`default_nettype wire

//--- verif/xbc_ext_master.sv
/*
 * Behavioural model of an outside bus master that asks the device for the bus.
 * Assumes the bench sets want_in just after a rising edge and watches the device acknowledge.
 */
`timescale 1ns/1ps
`default_nettype none

module xbc_ext_master (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic want_in,
	input wire logic bus_ack_n_in,
	output logic bus_release_request_n_out,
	output logic owns_bus_out
);
	// ========================================
	// request line
	// held low as long as the bus is wanted; a real master does not drop it early
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			bus_release_request_n_out <= 1'b1;
		else
			bus_release_request_n_out <= !want_in;
	end

	assign owns_bus_out = !bus_ack_n_in && !bus_release_request_n_out;
endmodule

`default_nettype wire

//--- verilog/xbc_area_config.sv
/*
 * Configuration register bank of the external bus area controller: per-area width,
 * access length and wait settings, bus release enable, access snapshot and release arbiter.
 * Assumes a CPU register port on clk_in with one-cycle strobes and read data in the next cycle;
 * the mode strap, hardware standby and bus request pins are asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module xbc_area_config (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [1:0] mode_pins_in,
	input wire logic hw_standby_in,
	input wire logic [15:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	input wire logic access_start_in,
	input wire logic [2:0] access_area_in,
	input wire logic access_onchip_in,
	input wire logic access_done_in,
	output xbc_pkg::xbc_spec_t access_spec_out,
	output logic bus_busy_out,
	output logic bus16_mode_out,
	output logic port4_gpio_out,
	output logic release_pins_gpio_out,
	input wire logic bus_release_request_n_in,
	output logic bus_ack_n_out,
	output logic bus_ack_oe_out,
	output logic bus_granted_out
);

	// ========================================
	// pin synchronisers
	logic [1:0] mode_sync;
	logic standby_sync;
	logic request_n_sync;

	xbc_sync #(.W(2)) u_mode_sync (
		.clk_in(clk_in),
		.d_in(mode_pins_in),
		.q_out(mode_sync)
	);

	xbc_sync #(.W(2)) u_ctl_sync (
		.clk_in(clk_in),
		.d_in({hw_standby_in, bus_release_request_n_in}),
		.q_out({standby_sync, request_n_sync})
	);

	// mode_sync: 0..3 stand for modes 1..4
	logic narrow_mode;
	logic top_bits_writable;
	logic init;
	assign narrow_mode = !mode_sync[0];
	assign top_bits_writable = mode_sync[1];
	// hardware standby initialises like reset; software standby has no input here, so it keeps all
	assign init = rst_in || standby_sync;

	// ========================================
	// register decode
	logic sel_width;
	logic sel_state;
	logic sel_wmode;
	logic sel_wen;
	logic sel_release;
	assign sel_width = (addr_in == xbc_pkg::OFS_AREA_WIDTH);
	assign sel_state = (addr_in == xbc_pkg::OFS_AREA_STATE);
	assign sel_wmode = (addr_in == xbc_pkg::OFS_WAIT_MODE);
	assign sel_wen = (addr_in == xbc_pkg::OFS_WAIT_ENABLE);
	assign sel_release = (addr_in == xbc_pkg::OFS_BUS_RELEASE);

	// ========================================
	// configuration registers
	logic [7:0] width_reg;
	logic [7:0] state_reg;
	logic [3:0] wmode_reg;
	logic [7:0] wen_reg;
	logic [2:0] release_top_reg;
	logic release_en_reg;

	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			width_reg <= narrow_mode ? xbc_pkg::RST_WIDTH_NARROW : xbc_pkg::RST_WIDTH_WIDE;
		end
		else if (wr_en_in && sel_width)
		begin
			width_reg <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			state_reg <= xbc_pkg::RST_AREA_STATE;
		end
		else if (wr_en_in && sel_state)
		begin
			state_reg <= wr_data_in;
		end
	end

	// only the low nibble is stored; the upper one is constant ones
	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			wmode_reg <= xbc_pkg::RST_WAIT_MODE[3:0];
		end
		else if (wr_en_in && sel_wmode)
		begin
			wmode_reg <= wr_data_in[3:0];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			wen_reg <= xbc_pkg::RST_WAIT_ENABLE;
		end
		else if (wr_en_in && sel_wen)
		begin
			wen_reg <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			release_top_reg <= xbc_pkg::RST_BUS_RELEASE[7:5];
			release_en_reg <= xbc_pkg::RST_BUS_RELEASE[xbc_pkg::RELEASE_EN_BIT];
		end
		else if (wr_en_in && sel_release)
		begin
			release_en_reg <= wr_data_in[xbc_pkg::RELEASE_EN_BIT];
			if (top_bits_writable)
			begin
				release_top_reg <= wr_data_in[7:5];
			end
		end
	end

	// ========================================
	// read port: data valid in the cycle after the strobe
	logic [7:0] release_view;
	assign release_view = {top_bits_writable ? release_top_reg : xbc_pkg::RELEASE_TOP_ONES,
		xbc_pkg::RELEASE_MID_ONES, release_en_reg};

	always_ff @(posedge clk_in)
	begin
		if (rst_in || !rd_en_in)
		begin
			rd_data_out <= xbc_pkg::RD_UNMAPPED;
		end
		else if (sel_width)
		begin
			rd_data_out <= width_reg;
		end
		else if (sel_state)
		begin
			rd_data_out <= state_reg;
		end
		else if (sel_wmode)
		begin
			rd_data_out <= {xbc_pkg::WAIT_FIXED_ONES, wmode_reg};
		end
		else if (sel_wen)
		begin
			rd_data_out <= wen_reg;
		end
		else if (sel_release)
		begin
			rd_data_out <= release_view;
		end
		else
		begin
			rd_data_out <= xbc_pkg::RD_UNMAPPED;
		end
	end

	// ========================================
	// bus specification of the next access
	xbc_pkg::xbc_cfg_t cfg;
	xbc_pkg::xbc_spec_t spec_next;
	always_comb
	begin
		cfg.width_n16 = width_reg;
		cfg.three_state = state_reg;
		cfg.wait_mode = xbc_pkg::xbc_wait_mode_t'(wmode_reg[xbc_pkg::WAIT_MODE_LSB +: 2]);
		cfg.wait_count = wmode_reg[xbc_pkg::WAIT_COUNT_LSB +: 2];
		cfg.wait_unit_en = wen_reg;
		cfg.release_en = release_en_reg;
	end

	xbc_spec_decode u_decode (
		.cfg_in(cfg),
		.area_in(access_area_in),
		.onchip_in(access_onchip_in),
		.spec_out(spec_next)
	);

	// ========================================
	// access sequencing and bus release
	xbc_pkg::xbc_state_t state_q;
	xbc_pkg::xbc_state_t state_next;
	logic want_release;
	assign want_release = release_en_reg && !request_n_sync;

	always_comb
	begin
		case (state_q)
			xbc_pkg::XBC_ST_IDLE:
			begin
				// the CPU wins a tie so a started cycle is never cut off
				if (access_start_in)
				begin
					state_next = xbc_pkg::XBC_ST_BUSY;
				end
				else if (want_release)
				begin
					state_next = xbc_pkg::XBC_ST_RELEASED;
				end
				else
				begin
					state_next = xbc_pkg::XBC_ST_IDLE;
				end
			end
			xbc_pkg::XBC_ST_BUSY:
			begin
				state_next = access_done_in ? xbc_pkg::XBC_ST_IDLE : xbc_pkg::XBC_ST_BUSY;
			end
			xbc_pkg::XBC_ST_RELEASED:
			begin
				// clearing the enable also takes the bus back at once
				state_next = want_release ? xbc_pkg::XBC_ST_RELEASED : xbc_pkg::XBC_ST_IDLE;
			end
			default:
			begin
				state_next = xbc_pkg::XBC_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			state_q <= xbc_pkg::XBC_ST_IDLE;
		end
		else
		begin
			state_q <= state_next;
		end
	end

	// snapshot taken at start: later writes cannot disturb the running cycle
	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			access_spec_out <= '0;
		end
		else if (state_q == xbc_pkg::XBC_ST_IDLE && access_start_in)
		begin
			access_spec_out <= spec_next;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			bus_busy_out <= 1'b0;
			bus_granted_out <= 1'b0;
			bus_ack_n_out <= 1'b1;
			bus_ack_oe_out <= 1'b0;
		end
		else
		begin
			bus_busy_out <= (state_next == xbc_pkg::XBC_ST_BUSY);
			bus_granted_out <= (state_next == xbc_pkg::XBC_ST_RELEASED);
			bus_ack_n_out <= (state_next != xbc_pkg::XBC_ST_RELEASED);
			bus_ack_oe_out <= release_en_reg;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (init)
		begin
			bus16_mode_out <= !narrow_mode;
			port4_gpio_out <= narrow_mode;
			release_pins_gpio_out <= 1'b1;
		end
		else
		begin
			bus16_mode_out <= (width_reg != xbc_pkg::RST_WIDTH_NARROW);
			port4_gpio_out <= (width_reg == xbc_pkg::RST_WIDTH_NARROW);
			release_pins_gpio_out <= !release_en_reg;
		end
	end

	// ========================================
	// assertions
	a_width_init: assert property (@(posedge clk_in) rst_in && $stable(mode_sync) |=>
		width_reg == ($past(narrow_mode) ? 8'hFF : 8'h00))
		else $error("width register not initialised for mode");
	a_state_init: assert property (@(posedge clk_in) rst_in |=> state_reg == 8'hFF && wen_reg == 8'hFF)
		else $error("state or wait enable register not all ones after reset");
	a_wait_init: assert property (@(posedge clk_in) rst_in
		|=> wmode_reg == 4'h3)
		else $error("wait control not F3 after reset");
	a_wait_upper_ones: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_en_in && sel_wmode |=> rd_data_out[7:4] == 4'hF)
		else $error("wait control upper bits not ones");
	a_release_mid_ones: assert property (@(posedge clk_in) disable iff (rst_in)
		rd_en_in && sel_release |=> rd_data_out[4:1] == 4'hF
		&& (mode_sync[1] || rd_data_out[7:5] == 3'h7))
		else $error("release control reserved bits wrong");
	a_grant_needs_en: assert property (@(posedge clk_in) disable iff (rst_in)
		$rose(bus_granted_out) |-> $past(release_en_reg) && !bus_ack_n_out)
		else $error("bus granted while release disabled");
	a_snapshot_hold: assert property (@(posedge clk_in) disable iff (init)
		bus_busy_out && !access_done_in |=> $stable(access_spec_out))
		else $error("access spec changed during cycle");
	a_onchip_fixed: assert property (@(posedge clk_in) disable iff (init)
		state_q == xbc_pkg::XBC_ST_IDLE && access_start_in && access_onchip_in
		|=> access_spec_out.bus16 && !access_spec_out.three_state)
		else $error("on-chip access took area settings");
	a_bus_mode: assert property (@(posedge clk_in) disable iff (init)
		width_reg == 8'hFF |=> port4_gpio_out && !bus16_mode_out)
		else $error("8-bit bus mode not entered");
	a_width_select: assert property (@(posedge clk_in) disable iff (init)
		state_q == xbc_pkg::XBC_ST_IDLE && access_start_in && !access_onchip_in
		|=> access_spec_out.bus16 == !$past(width_reg[access_area_in]))
		else $error("area width not applied");

	c_release: cover property (@(posedge clk_in) $rose(bus_granted_out));
	c_ext_access: cover property (@(posedge clk_in) bus_busy_out ##1 !bus_busy_out);
	c_write_read: cover property (@(posedge clk_in) wr_en_in && sel_wmode ##1 rd_en_in && sel_wmode);

endmodule
`default_nettype wire

//--- verilog/xbc_pkg.sv
/*
 * Shared constants and types of the external bus area configuration bank.
 * Assumes a single 50 MHz clock and a CPU-side register port of 16-bit address, 8-bit data.
 */

package xbc_pkg;

	// ========================================
	// register map, lower sixteen address bits
	localparam logic [15:0] OFS_AREA_WIDTH = 16'hFFEC;
	localparam logic [15:0] OFS_AREA_STATE = 16'hFFED;
	localparam logic [15:0] OFS_WAIT_MODE = 16'hFFEE;
	localparam logic [15:0] OFS_WAIT_ENABLE = 16'hFFEF;
	localparam logic [15:0] OFS_BUS_RELEASE = 16'hFFF3;

	// ========================================
	// reset values
	localparam logic [7:0] RST_WIDTH_NARROW = 8'hFF;
	localparam logic [7:0] RST_WIDTH_WIDE = 8'h00;
	localparam logic [7:0] RST_AREA_STATE = 8'hFF;
	localparam logic [7:0] RST_WAIT_MODE = 8'hF3;
	localparam logic [7:0] RST_WAIT_ENABLE = 8'hFF;
	localparam logic [7:0] RST_BUS_RELEASE = 8'hFE;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// ========================================
	// field positions
	localparam int WAIT_MODE_LSB = 2;
	localparam int WAIT_COUNT_LSB = 0;
	localparam int RELEASE_EN_BIT = 0;
	localparam logic [3:0] WAIT_FIXED_ONES = 4'hF;
	localparam logic [3:0] RELEASE_MID_ONES = 4'hF;
	localparam logic [2:0] RELEASE_TOP_ONES = 3'h7;
	localparam logic [1:0] ONCHIP_WAITS = 2'h0;

	// ========================================
	// types
	typedef enum logic [1:0] {
		XBC_WM_PROGRAM = 2'h0,
		XBC_WM_NONE = 2'h1,
		XBC_WM_PIN1 = 2'h2,
		XBC_WM_PIN_AUTO = 2'h3
	} xbc_wait_mode_t;

	// effective wait behaviour of one access after all selections are combined
	typedef enum logic [2:0] {
		XBC_EW_NONE = 3'h0,
		XBC_EW_PROGRAM = 3'h1,
		XBC_EW_PIN0 = 3'h2,
		XBC_EW_PIN1 = 3'h3,
		XBC_EW_PIN_AUTO = 3'h4
	} xbc_eff_wait_t;

	typedef enum logic [2:0] {
		XBC_ST_IDLE = 3'h1,
		XBC_ST_BUSY = 3'h2,
		XBC_ST_RELEASED = 3'h4
	} xbc_state_t;

	typedef struct packed {
		logic [7:0] width_n16;
		logic [7:0] three_state;
		xbc_wait_mode_t wait_mode;
		logic [1:0] wait_count;
		logic [7:0] wait_unit_en;
		logic release_en;
	} xbc_cfg_t;

	typedef struct packed {
		logic bus16;
		logic three_state;
		xbc_eff_wait_t wait_kind;
		logic [1:0] wait_count;
		logic pin_wait_allowed;
	} xbc_spec_t;

endpackage

//--- verilog/xbc_spec_decode.sv
/*
 * Combines the configuration of one area into the bus specification of an access.
 * Assumes the area index and on-chip flag come from the address decoder on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module xbc_spec_decode (
	input wire xbc_pkg::xbc_cfg_t cfg_in,
	input wire logic [2:0] area_in,
	input wire logic onchip_in,
	output xbc_pkg::xbc_spec_t spec_out
);

	always_comb
	begin
		spec_out.bus16 = !cfg_in.width_n16[area_in];
		spec_out.three_state = cfg_in.three_state[area_in];
		spec_out.wait_count = xbc_pkg::ONCHIP_WAITS;
		spec_out.pin_wait_allowed = 1'b0;
		if (!cfg_in.three_state[area_in])
		begin
			spec_out.wait_kind = xbc_pkg::XBC_EW_NONE;
		end
		else if (!cfg_in.wait_unit_en[area_in])
		begin
			spec_out.wait_kind = xbc_pkg::XBC_EW_PIN0;
			spec_out.pin_wait_allowed = 1'b1;
		end
		else
		begin
			case (cfg_in.wait_mode)
				xbc_pkg::XBC_WM_PROGRAM:
				begin
					spec_out.wait_kind = xbc_pkg::XBC_EW_PROGRAM;
					spec_out.wait_count = cfg_in.wait_count;
				end
				xbc_pkg::XBC_WM_PIN1:
				begin
					spec_out.wait_kind = xbc_pkg::XBC_EW_PIN1;
					spec_out.wait_count = cfg_in.wait_count;
					spec_out.pin_wait_allowed = 1'b1;
				end
				xbc_pkg::XBC_WM_PIN_AUTO:
				begin
					spec_out.wait_kind = xbc_pkg::XBC_EW_PIN_AUTO;
					spec_out.wait_count = cfg_in.wait_count;
					spec_out.pin_wait_allowed = 1'b1;
				end
				default:
				begin
					spec_out.wait_kind = xbc_pkg::XBC_EW_NONE;
				end
			endcase
		end
		// on-chip memory and registers ignore all area settings
		if (onchip_in)
		begin
			spec_out.bus16 = 1'b1;
			spec_out.three_state = 1'b0;
			spec_out.wait_kind = xbc_pkg::XBC_EW_NONE;
			spec_out.wait_count = xbc_pkg::ONCHIP_WAITS;
			spec_out.pin_wait_allowed = 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- verilog/xbc_sync.sv
/*
 * Three-stage input synchroniser with agreement filter.
 * Assumes the input is asynchronous to clk_in; the result is undefined until four edges have passed.
 */
`timescale 1ns/1ps
`default_nettype none

module xbc_sync #(
	parameter int W = 1
) (
	input wire logic clk_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// no reset: pins must be sampled even while reset is held, so reset values can depend on them
	always_ff @(posedge clk_in)
	begin
		s1_reg <= d_in;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end

	// agreement is judged per bit so that unrelated pins sharing one instance do not hold each other up
	always_ff @(posedge clk_in)
	begin
		q_out <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_out);
	end

endmodule
`default_nettype wire
